// ### design/trace_config_ext_input_regs.sv
/*
 * trace_config_ext_input_regs: configuration code extension, extended
 * input selection and auxiliary control registers of the flow trace
 * unit, on an AHB-Lite slave, with the small gating that the auxiliary
 * controls apply to timestamp, synchronization and waypoint packets.
 * Assumes a single clock; all inputs synchronous to clk.
 */
`default_nettype none

module trace_config_ext_input_regs
    import tcx_pkg::*;
#(
    parameter int EXT_BUS_W = 88,
    parameter int NUM_SEL   = 2
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // extended external inputs and the chosen lines
    input  wire logic [EXT_BUS_W-1:0]  extIn,
    output logic [NUM_SEL-1:0]         extSelOut,
    // trace activity and packet requests from the trace core
    input  wire logic                  activityHigh,
    input  wire logic                  tsRequest,
    input  wire logic                  syncRequest,
    input  wire logic                  excEvent,
    input  wire logic                  barrierEvent,
    input  wire logic                  memSyncBarrier,
    input  wire logic                  instrValid,
    input  wire logic [3:0]            instrBytes,
    input  wire logic                  waypoint,
    input  wire logic                  excOrDebugEntry,
    // packet permissions back to the trace core, registered one cycle after the requests
    output logic                       tsIssue,
    output logic                       syncIssue,
    output logic                       tsOnException,
    output logic                       tsOnBarrier,
    output logic                       waypointUpdate,
    // auxiliary control levels
    output logic                       forceTimestamp,
    output logic                       delaySync,
    output logic                       noWaypointUpdate,
    output logic                       noTsException,
    output logic                       noTsBarrier,
    output logic                       noForcedOverflow
);

    // refuse sizes that the fixed register layout cannot carry
    if (NUM_SEL != 2) begin : g_bad_nsel
        $error("NUM_SEL must be 2 to match the selection layout");
    end
    if (EXT_BUS_W < 1 || EXT_BUS_W > (1 << TCX_SEL_W)) begin : g_bad_bus
        $error("EXT_BUS_W must lie between 1 and 128");
    end

    // bus front end strobes
    logic                  rdStb;
    logic [TCX_ADDR_W-1:0] rdAddr;
    logic                  wrStb;
    logic [TCX_ADDR_W-1:0] wrAddr;
    tcx_reg_e              rdReg;
    tcx_reg_e              wrReg;

    tcx_ahb_slave u_slave (
        .clk       (clk),
        .arst_n    (arst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rdStb     (rdStb),
        .rdAddr    (rdAddr),
        .wrStb     (wrStb),
        .wrAddr    (wrAddr)
    );

    // the size field is not decoded: only whole words are used
    logic unusedSize;
    assign unusedSize = ^hsize;

    assign rdReg = tcx_decode(rdAddr);
    assign wrReg = tcx_decode(wrAddr);

    // fixed capability word
    logic [31:0] cceValue;
    assign cceValue = {
        TCX_CCE_TOP_SBZ,
        TCX_CCE_TS64,
        TCX_CCE_TSBIN,
        TCX_CCE_REDCNT,
        TCX_CCE_VIRT,
        TCX_CCE_BARTS,
        TCX_CCE_BARWP,
        TCX_CCE_RETSTK,
        TCX_CCE_TSIMPL,
        TCX_CCE_RAZ,
        TCX_CCE_INSTR,
        TCX_CCE_RAO,
        TCX_CCE_ALLRD,
        TCX_CCE_EXTBUS,
        TCX_CCE_NSEL
    };

    // stored fields
    logic [TCX_SEL_W-1:0] selIdx [NUM_SEL];
    logic [TCX_SEL_W-1:0] next_selIdx [NUM_SEL];
    logic [TCX_AUX_W-1:0] aux;
    logic [TCX_AUX_W-1:0] next_aux;
    logic                 selWrite;
    logic                 auxWrite;

    // the capability register has no write path at all
    assign selWrite = wrStb & (wrReg == TCX_REG_SEL);
    assign auxWrite = wrStb & (wrReg == TCX_REG_AUX);

    // selector fields taken from their byte-aligned slots
    assign next_selIdx[0] = selWrite
        ? hwdata[TCX_SEL0_LSB +: TCX_SEL_W] : selIdx[0];
    assign next_selIdx[1] = selWrite
        ? hwdata[TCX_SEL1_LSB +: TCX_SEL_W] : selIdx[1];
    assign next_aux = auxWrite ? hwdata[TCX_AUX_W-1:0] : aux;

    // selector and auxiliary storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selIdx[0] <= TCX_SEL_RST;
            selIdx[1] <= TCX_SEL_RST;
            aux       <= TCX_AUX_RST;
        end else begin
            selIdx[0] <= next_selIdx[0];
            selIdx[1] <= next_selIdx[1];
            aux       <= next_aux;
        end
    end

    // read words built from the values after any write in flight
    logic [31:0] selWord;
    logic [31:0] auxWord;
    logic [31:0] readMux;

    assign selWord = {17'h00000, next_selIdx[1], 1'b0,
                      next_selIdx[0]};
    assign auxWord = {26'h0000000, next_aux};
    assign readMux = (rdReg == TCX_REG_CCE) ? cceValue :
                     (rdReg == TCX_REG_SEL) ? selWord  :
                     (rdReg == TCX_REG_AUX) ? auxWord  :
                     32'h00000000;

    // read data captured in the address phase, shown in the data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h00000000;
        end else if (rdStb) begin
            hrdata <= readMux;
        end
    end

    // one chooser for each selector resource
    for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
        tcx_ext_sel #(
            .BUS_W (EXT_BUS_W),
            .IDX_W (TCX_SEL_W)
        ) u_sel (
            .clk    (clk),
            .arst_n (arst_n),
            .extIn  (extIn),
            .index  (selIdx[g]),
            .selOut (extSelOut[g])
        );
    end

    // auxiliary control levels straight from the register
    assign forceTimestamp   = aux[TCX_AUX_FORCETS];
    assign delaySync        = aux[TCX_AUX_DLYSYNC];
    assign noWaypointUpdate = aux[TCX_AUX_NOWPUPD];
    assign noTsException    = aux[TCX_AUX_NOTSEXC];
    assign noTsBarrier      = aux[TCX_AUX_NOTSBAR];
    assign noForcedOverflow = aux[TCX_AUX_NOOVF];

    // packet permissions from requests, activity and the controls
    logic next_tsIssue;
    logic next_syncIssue;
    logic next_tsOnException;
    logic next_tsOnBarrier;

    assign next_tsIssue = tsRequest
        & (forceTimestamp | ~activityHigh);
    assign next_syncIssue = syncRequest
        & ~(delaySync & activityHigh);
    assign next_tsOnException = excEvent & ~noTsException;
    // memory and sync barriers never carry a timestamp
    assign next_tsOnBarrier = barrierEvent & ~memSyncBarrier
        & ~noTsBarrier;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tsIssue       <= 1'b0;
            syncIssue     <= 1'b0;
            tsOnException <= 1'b0;
            tsOnBarrier   <= 1'b0;
        end else begin
            tsIssue       <= next_tsIssue;
            syncIssue     <= next_syncIssue;
            tsOnException <= next_tsOnException;
            tsOnBarrier   <= next_tsOnBarrier;
        end
    end

    // bytes of program flow since the last waypoint
    logic [TCX_GAP_W-1:0] gapCount;
    logic [TCX_GAP_W-1:0] next_gapCount;
    logic [TCX_GAP_W:0]   gapSum;
    logic                 gapOver;
    logic                 next_waypointUpdate;

    // barrier instructions do not count as waypoints here
    assign gapSum  = {1'b0, gapCount}
                   + (TCX_GAP_W+1)'(instrValid ? instrBytes : 4'h0);
    assign gapOver = (gapCount > TCX_WP_GAP);
    assign next_waypointUpdate = excOrDebugEntry
        | (gapOver & ~noWaypointUpdate);

    // counter restarts on a waypoint or an update; it saturates
    assign next_gapCount =
        (waypoint | next_waypointUpdate) ? '0 :
        gapSum[TCX_GAP_W] ? {TCX_GAP_W{1'b1}} :
        gapSum[TCX_GAP_W-1:0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gapCount       <= '0;
            waypointUpdate <= 1'b0;
        end else begin
            gapCount       <= next_gapCount;
            waypointUpdate <= next_waypointUpdate;
        end
    end

endmodule

`default_nettype wire

// ### design/tcx_pkg.sv
/*
 * tcx_pkg: shared constants, register map, field layouts and the address
 * decoder of the trace configuration extension and input register bank.
 * Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
 */
`default_nettype none

package tcx_pkg;

    // register map, byte offsets inside the bank window
    localparam int          TCX_ADDR_W      = 12;
    localparam logic [11:0] TCX_OFS_CCE     = 12'h000;
    localparam logic [11:0] TCX_OFS_SEL     = 12'h004;
    localparam logic [11:0] TCX_OFS_AUX     = 12'h008;

    // capability fields of the configuration code extension register
    localparam logic [1:0]  TCX_CCE_TOP_SBZ = 2'h0;   // bits 31:30
    localparam logic        TCX_CCE_TS64    = 1'h1;   // bit 29
    localparam logic        TCX_CCE_TSBIN   = 1'h1;   // bit 28
    localparam logic        TCX_CCE_REDCNT  = 1'h0;   // bit 27
    localparam logic        TCX_CCE_VIRT    = 1'h1;   // bit 26
    localparam logic        TCX_CCE_BARTS   = 1'h0;   // bit 25
    localparam logic        TCX_CCE_BARWP   = 1'h0;   // bit 24
    localparam logic        TCX_CCE_RETSTK  = 1'h1;   // bit 23
    localparam logic        TCX_CCE_TSIMPL  = 1'h1;   // bit 22
    localparam logic [5:0]  TCX_CCE_RAZ     = 6'h00;  // bits 21:16
    localparam logic [2:0]  TCX_CCE_INSTR   = 3'h0;   // bits 15:13
    localparam logic        TCX_CCE_RAO     = 1'h1;   // bit 12
    localparam logic        TCX_CCE_ALLRD   = 1'h1;   // bit 11
    localparam logic [7:0]  TCX_CCE_EXTBUS  = 8'h58;  // bits 10:3, 88
    localparam logic [2:0]  TCX_CCE_NSEL    = 3'h2;   // bits 2:0

    // selection register layout
    localparam int          TCX_SEL_W       = 7;
    localparam int          TCX_SEL0_LSB    = 0;
    localparam int          TCX_SEL1_LSB    = 8;
    localparam logic [6:0]  TCX_SEL_RST     = 7'h00;

    // auxiliary control layout
    localparam int          TCX_AUX_W       = 6;
    localparam int          TCX_AUX_NOOVF   = 0;
    localparam int          TCX_AUX_NOTSBAR = 1;
    localparam int          TCX_AUX_NOTSEXC = 2;
    localparam int          TCX_AUX_NOWPUPD = 3;
    localparam int          TCX_AUX_DLYSYNC = 4;
    localparam int          TCX_AUX_FORCETS = 5;
    localparam logic [5:0]  TCX_AUX_RST     = 6'h00;

    // waypoint update gap, in bytes of program flow
    localparam int          TCX_GAP_W       = 14;
    localparam logic [13:0] TCX_WP_GAP      = 14'h1000;

    // which register an address falls on
    typedef enum logic [1:0] {
        TCX_REG_NONE = 2'b00,
        TCX_REG_CCE  = 2'b01,
        TCX_REG_SEL  = 2'b10,
        TCX_REG_AUX  = 2'b11
    } tcx_reg_e;

    function automatic tcx_reg_e tcx_decode(input logic [11:0] addr);
        tcx_reg_e r;
        r = TCX_REG_NONE;
        if (addr == TCX_OFS_CCE) begin
            r = TCX_REG_CCE;
        end else if (addr == TCX_OFS_SEL) begin
            r = TCX_REG_SEL;
        end else if (addr == TCX_OFS_AUX) begin
            r = TCX_REG_AUX;
        end
        return r;
    endfunction

endpackage

`default_nettype wire

// ### design/tcx_ahb_slave.sv
/*
 * tcx_ahb_slave: AHB-Lite slave front end with zero wait states.
 * Gives a read strobe in the address phase and a write strobe with its
 * address in the data phase. Assumes single word transfers only.
 */
`default_nettype none

module tcx_ahb_slave
    import tcx_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // bus address phase
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic                  hready,
    // bus answer
    output logic                       hreadyout,
    output logic                       hresp,
    // register side
    output logic                       rdStb,
    output logic [TCX_ADDR_W-1:0]      rdAddr,
    output logic                       wrStb,
    output logic [TCX_ADDR_W-1:0]      wrAddr
);

    logic addrPhase;

    // a transfer is taken when selected, active and the bus is ready
    assign addrPhase = hsel & hready & htrans[1];
    assign rdStb     = addrPhase & ~hwrite;
    assign rdAddr    = haddr[TCX_ADDR_W-1:0];

    // write is carried into the data phase, where hwdata stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrStb  <= 1'b0;
            wrAddr <= '0;
        end else begin
            wrStb  <= addrPhase & hwrite;
            wrAddr <= addrPhase ? haddr[TCX_ADDR_W-1:0] : wrAddr;
        end
    end

    // never waits and always answers okay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### design/tcx_ext_sel.sv
/*
 * tcx_ext_sel: picks one line of the extended external input bus.
 * An index past the bus gives zero. Inputs are synchronous to clk.
 */
`default_nettype none

module tcx_ext_sel #(
    parameter int BUS_W = 88,
    parameter int IDX_W = 7
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // inputs and index
    input  wire logic [BUS_W-1:0]  extIn,
    input  wire logic [IDX_W-1:0]  index,
    // chosen line, registered
    output logic                   selOut
);

    logic inRange;
    logic picked;

    // out-of-range indices read as an idle input
    assign inRange = ({1'b0, index} < (IDX_W+1)'(BUS_W));
    assign picked  = inRange ? extIn[index] : 1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selOut <= 1'b0;
        end else begin
            selOut <= picked;
        end
    end

endmodule

`default_nettype wire

// ### dv/tcx_regs_checker_assertions.sv
/*
 * tcx_regs_checker: port checker of the trace configuration register bank.
 * Assumes it is bound onto trace_config_ext_input_regs, one clock domain.
 */
`default_nettype none

module tcx_regs_checker (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic [31:0] hrdata,
    // trace core requests
    input  wire logic        activityHigh,
    input  wire logic        tsRequest,
    input  wire logic        syncRequest,
    input  wire logic        excEvent,
    input  wire logic        barrierEvent,
    input  wire logic        memSyncBarrier,
    input  wire logic        excOrDebugEntry,
    // packet permissions and control levels
    input  wire logic        tsIssue,
    input  wire logic        syncIssue,
    input  wire logic        tsOnException,
    input  wire logic        tsOnBarrier,
    input  wire logic        waypointUpdate,
    input  wire logic        forceTimestamp,
    input  wire logic        delaySync,
    input  wire logic        noWaypointUpdate,
    input  wire logic        noTsException,
    input  wire logic        noTsBarrier,
    input  wire logic        noForcedOverflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // read address phase taken, and its register
    logic takeRd;
    logic auxWr;
    logic capRd;
    assign takeRd = hsel && hready && htrans[1] && !hwrite;
    assign capRd  = takeRd && haddr[11:0] == 12'h000;

    // marks the data phase of a write to the auxiliary control register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auxWr <= 1'b0;
        end else if (hready) begin
            auxWr <= hsel && htrans[1] && hwrite && haddr[11:0] == 12'h008;
        end
    end

    a_cap_ts: assert property (capRd |=>
        hrdata[29:28] == 2'h3 && hrdata[22])
        else $error("timestamp capability bits differ");
    a_cap_core: assert property (capRd |=>
        hrdata[27:23] == 5'h09) else $error("core capability bits differ");
    a_cap_value: assert property (capRd |=>
        hrdata[31:30] == 2'h0 && hrdata[21:0] == 22'h001ac2)
        else $error("capability read differs");
    a_sel_reserved: assert property (takeRd
        && haddr[11:0] == 12'h004 |=> hrdata[31:15] == 17'h0 && !hrdata[7])
        else $error("selection reserved bits not zero");
    a_aux_reserved: assert property (takeRd
        && haddr[11:0] == 12'h008 |=> hrdata[31:6] == 26'h0)
        else $error("aux reserved bits not zero");
    a_ts_gate: assert property ($past(arst_n) |-> tsIssue ==
        $past(tsRequest && (forceTimestamp || !activityHigh)))
        else $error("timestamp gate wrong");
    a_sync_gate: assert property ($past(arst_n) |-> syncIssue ==
        $past(syncRequest && !(delaySync && activityHigh)))
        else $error("sync gate wrong");
    a_exc_ts: assert property ($past(arst_n) |-> tsOnException ==
        $past(excEvent && !noTsException)) else $error("exception ts wrong");
    a_barrier_ts: assert property ($past(arst_n) |->
        tsOnBarrier == $past(barrierEvent && !memSyncBarrier && !noTsBarrier))
        else $error("barrier ts wrong");
    a_wp_forced: assert property ($past(arst_n)
        && $past(excOrDebugEntry) |-> waypointUpdate)
        else $error("entry update missing");
    a_wp_quiet: assert property ($past(arst_n)
        && $past(noWaypointUpdate) && !$past(excOrDebugEntry)
        |-> !waypointUpdate) else $error("update while disabled");
    a_aux_load: assert property (auxWr && hready
        |=> {forceTimestamp, delaySync, noWaypointUpdate, noTsException,
         noTsBarrier, noForcedOverflow} == $past(hwdata[5:0]))
        else $error("aux levels not loaded");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");

    c_cap_read: cover property (takeRd && haddr[11:0] == 12'h000);
    c_aux_write: cover property (auxWr && hready);
    c_wp_update: cover property (waypointUpdate && !$past(excOrDebugEntry));
    c_forced_ts: cover property (tsIssue && $past(activityHigh));
endmodule

bind trace_config_ext_input_regs tcx_regs_checker i_chk (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .activityHigh(activityHigh), .tsRequest(tsRequest),
    .syncRequest(syncRequest), .excEvent(excEvent),
    .barrierEvent(barrierEvent), .memSyncBarrier(memSyncBarrier),
    .excOrDebugEntry(excOrDebugEntry), .tsIssue(tsIssue),
    .syncIssue(syncIssue), .tsOnException(tsOnException),
    .tsOnBarrier(tsOnBarrier), .waypointUpdate(waypointUpdate),
    .forceTimestamp(forceTimestamp), .delaySync(delaySync),
    .noWaypointUpdate(noWaypointUpdate), .noTsException(noTsException),
    .noTsBarrier(noTsBarrier), .noForcedOverflow(noForcedOverflow));

`default_nettype wire

// ### dv/trace_config_ext_input_regs_tb.sv
/*
 * trace_config_ext_input_regs_tb: self-checking bench of the register bank.
 * Assumes one bus slave, so hready is the design's own hreadyout.
 */
`default_nettype none

module trace_config_ext_input_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, arst_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans, extSelOut;
    logic [2:0]  hsize;
    wire logic   hready;
    logic        hreadyout, hresp, activityHigh, tsRequest, syncRequest;
    logic        excEvent, barrierEvent, memSyncBarrier, instrValid;
    logic        waypoint, excOrDebugEntry, tsIssue, syncIssue, tsOnException;
    logic        tsOnBarrier, waypointUpdate, forceTimestamp, delaySync;
    logic        noWaypointUpdate, noTsException, noTsBarrier, noForcedOverflow;
    logic [3:0]  instrBytes, e;
    logic [87:0] extIn, xv;
    logic [95:0] w;
    logic [15:0] lfsr = 16'h000e;
    logic [15:0] r;
    logic [6:0]  s0, s1;
    int          bad_count = 0;
    int          comparisons = 0;
    int          hits;

    // capability value built field by field from bit 31 down
    localparam logic [31:0] CAP = {2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0,
        1'h1, 1'h1, 6'h00, 3'h0, 1'h1, 1'h1, 8'h58, 3'h2};

    assign hready = hreadyout;

    trace_config_ext_input_regs i_dut (.clk(clk), .arst_n(arst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .extIn(extIn), .extSelOut(extSelOut), .activityHigh(activityHigh),
        .tsRequest(tsRequest), .syncRequest(syncRequest),
        .excEvent(excEvent), .barrierEvent(barrierEvent),
        .memSyncBarrier(memSyncBarrier), .instrValid(instrValid),
        .instrBytes(instrBytes), .waypoint(waypoint),
        .excOrDebugEntry(excOrDebugEntry), .tsIssue(tsIssue),
        .syncIssue(syncIssue), .tsOnException(tsOnException),
        .tsOnBarrier(tsOnBarrier), .waypointUpdate(waypointUpdate),
        .forceTimestamp(forceTimestamp), .delaySync(delaySync),
        .noWaypointUpdate(noWaypointUpdate), .noTsException(noTsException),
        .noTsBarrier(noTsBarrier), .noForcedOverflow(noForcedOverflow));

    // next value of the pseudo random sequence
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // line the model expects from one selector
    function automatic logic pick(input logic [87:0] v, input logic [6:0] i);
        return (i < 7'h58) ? v[i] : 1'b0;
    endfunction

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    // waits for hready at a rising edge; only the watchdog ends a hang
    task automatic wait_rdy;
        @(posedge clk);
        while (hready !== 1'b1) begin
            @(posedge clk);
        end
    endtask

    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a,
                          input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // free running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        {arst_n, hsel, hwrite, haddr, hwdata, htrans, extIn} <= '0;
        {activityHigh, tsRequest, syncRequest, excEvent, barrierEvent} <= '0;
        {memSyncBarrier, instrValid, waypoint, excOrDebugEntry} <= '0;
        instrBytes <= 4'h0;
        hsize <= 3'h2;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_chk("capability", 32'h0, CAP);
        rd_chk("sel reset", 32'h4, 32'h0);
        rd_chk("aux reset", 32'h8, 32'h0);
        bus(1'b1, 32'h0, 32'hffffffff);
        rd_chk("capability kept", 32'h0, CAP);
        bus(1'b1, 32'hc, 32'hffffffff);
        rd_chk("unmapped", 32'hc, 32'h0);
        bus(1'b1, 32'h4, 32'hffffffff);
        rd_chk("sel mask", 32'h4, 32'h00007f7f);
        bus(1'b1, 32'h8, 32'hffffffff);
        rd_chk("aux mask", 32'h8, 32'h0000003f);
        // selectors over the last line, the first missing one and random
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            xv = w[87:0];
            s0 = (i == 0) ? 7'h57 : (i == 1) ? 7'h58 : r[6:0];
            s1 = (i == 0) ? 7'h58 : (i == 1) ? 7'h57 : r[14:8];
            extIn <= xv;
            bus(1'b1, 32'h4, {17'h0, s1, 1'b0, s0});
            @(posedge clk);
            @(negedge clk);
            chk("selected", {30'h0, pick(xv, s1),
                pick(xv, s0)}, extSelOut);
            @(posedge clk);
        end
        // every auxiliary setting against random packet requests
        for (int a = 0; a < 64; a++) begin
            bus(1'b1, 32'h8, a);
            @(negedge clk);
            chk("aux levels", a, {forceTimestamp, delaySync,
                noWaypointUpdate, noTsException, noTsBarrier,
                noForcedOverflow});
            for (int k = 0; k < 6; k++) begin
                @(posedge clk);
                r = rnd();
                {memSyncBarrier, barrierEvent, excEvent} <= r[5:3];
                {syncRequest, tsRequest, activityHigh} <= r[2:0];
                e[3] = r[1] & (a[5] | ~r[0]);
                e[2] = r[2] & ~(a[4] & r[0]);
                e[1] = r[3] & ~a[2];
                e[0] = r[4] & ~r[5] & ~a[1];
                @(posedge clk);
                @(negedge clk);
                chk("gates", e, {tsIssue, syncIssue,
                    tsOnException, tsOnBarrier});
            end
            @(posedge clk);
        end
        {activityHigh, tsRequest, syncRequest, excEvent, barrierEvent} <= '0;
        // 4096 bytes give no update, 8 more give one unless disabled
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 32'h8, m * 8);
            waypoint <= 1'b1;
            @(posedge clk);
            waypoint <= 1'b0;
            instrValid <= 1'b1;
            instrBytes <= 4'h8;
            hits = 0;
            for (int k = 0; k < 518; k++) begin
                @(posedge clk);
                @(negedge clk);
                if (waypointUpdate === 1'b1) hits++;
                if (k == 512) chk("early update", 0, hits);
                if (k == 513) chk("update edge", m == 0, hits);
            end
            @(posedge clk);
            instrValid <= 1'b0;
            chk("gap updates", m == 0, hits);
        end
        excOrDebugEntry <= 1'b1;
        @(posedge clk);
        excOrDebugEntry <= 1'b0;
        @(negedge clk);
        chk("entry update", 1, waypointUpdate);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_chk("aux after reset", 32'h8, 32'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
